// *** hw/fic_defines.svh ***
// Constants of the four-level interrupt controller: slots, vectors, resets.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef FIC_DEFINES_SVH
`define FIC_DEFINES_SVH

`define FIC_NUM_SLOTS 19
`define FIC_RESERVED_SLOTS 19'h2_A000
`define FIC_VEC_BASE 16'h0003
`define FIC_FLAG_RST 1'b0
`define FIC_PIN_RST 1'b1
`define FIC_SVC_RST 4'h0
`define FIC_SRC_EXT0 5'h00
`define FIC_SRC_TMR0 5'h01
`define FIC_SRC_EXT1 5'h02
`define FIC_SRC_TMR1 5'h03
`define FIC_SRC_UART0 5'h04
`define FIC_SRC_TMR2 5'h05
`define FIC_SRC_EXT2 5'h06
`define FIC_SRC_SPI 5'h07
`define FIC_SRC_ADC 5'h08
`define FIC_SRC_PCA 5'h09
`define FIC_SRC_SYS 5'h0a
`define FIC_SRC_KBD 5'h0b
`define FIC_SRC_TWI 5'h0c
`define FIC_SRC_UART1 5'h0e
`define FIC_SRC_TMR3 5'h10
`define FIC_SRC_DMA 5'h12

`endif

// *** hw/fic_pkg.sv ***
// Types shared by the interrupt controller modules.
// Assumes nothing beyond a SystemVerilog compiler.
package fic_pkg;

    // All request flags held by the controller
    typedef struct packed {
        logic       ext0_request_flag;
        logic       ext1_request_flag;
        logic       ext2_request_flag;
        logic       timer0_overflow_flag;
        logic       timer1_overflow_flag;
        logic       uart0_receive_flag;
        logic       uart0_transmit_flag;
        logic       uart1_receive_flag;
        logic       uart1_transmit_flag;
        logic       timer2_overflow_flag;
        logic       timer2_external_flag;
        logic       timer2_low_half_overflow;
        logic       timer3_overflow_flag;
        logic       timer3_external_flag;
        logic       timer3_low_half_overflow;
        logic       serial_periph_done_flag;
        logic       conversion_done_flag;
        logic       counter_array_overflow_flag;
        logic [5:0] compare_module_flags;
        logic       clock_overflow_flag;
        logic       brownout_zero_flag;
        logic       brownout_one_flag;
        logic       watchdog_overflow_flag;
        logic       bus_start_detect_flag;
        logic       bus_stop_detect_flag;
        logic       keypad_match_flag;
        logic       twi_state_flag;
        logic       dma_complete_flag;
        logic       dma_timer_a_flag;
        logic       dma_timer_b_flag;
    } fic_flags_t;

    // Priority rank: 3 is level 1 (highest), 0 is level 4
    typedef logic [1:0] fic_rank_t;

    // Request presented to the core
    typedef struct packed {
        logic       req;
        logic [4:0] src;
        logic [15:0] vector;
        fic_rank_t  rank;
    } fic_cpu_req_t;

endpackage : fic_pkg

// *** hw/fic_flag.sv ***
// One request flag: hardware set, software write, auto clear, follow mode.
// Assumes all controls come from logic on clk, already synchronised.
`timescale 1ns/1ps
`include "fic_defines.svh"
module fic_flag (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic hw_set,
    input  wire logic hw_clr,
    input  wire logic sw_wr,
    input  wire logic sw_data,
    input  wire logic follow,
    input  wire logic level,
    output logic      flag_r
);

    logic flag_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Next value: follow mode, then set over any clear
    always_comb begin
        if (follow) begin
            flag_nxt = level;
        end else if (hw_set) begin
            flag_nxt = 1'b1;
        end else if (sw_wr) begin
            flag_nxt = sw_data;
        end else if (hw_clr) begin
            flag_nxt = 1'b0;
        end else begin
            flag_nxt = flag_r;
        end
    end

    // Flag storage
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flag_r <= `FIC_FLAG_RST;
        end else begin
            flag_r <= flag_nxt;
        end
    end

endmodule : fic_flag

// *** hw/fic_top.sv ***
// Four-level interrupt controller: flags, gating, arbitration, vectoring.
// Assumes peripheral set pulses and core strobes are on clk; pins are async.
`timescale 1ns/1ps
`include "fic_defines.svh"
module fic_top
    import fic_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          resetn,
    input  wire logic          global_irq_enable,
    input  wire logic [18:0]   src_enable,
    input  wire logic [18:0]   priority_high_bit,
    input  wire logic [18:0]   priority_low_bit,
    input  wire logic          ext0_trigger_type,
    input  wire logic          ext1_trigger_type,
    input  wire logic          ext2_trigger_type,
    input  wire logic          uart_tx_sysflag_route,
    input  wire logic          ext_irq_pin_zero_n,
    input  wire logic          ext_irq_pin_one_n,
    input  wire logic          ext_irq_pin_two_n,
    input  wire fic_flags_t    hw_flag_set,
    input  wire fic_flags_t    sw_flag_wr,
    input  wire fic_flags_t    sw_flag_data,
    input  wire logic          vector_ack,
    input  wire logic          service_return,
    output fic_cpu_req_t       cpu_req,
    output fic_flags_t         flag_state,
    output logic [3:0]         in_service
);

    localparam int NF = $bits(fic_flags_t);
    localparam int NS = `FIC_NUM_SLOTS;
    localparam logic [NS-1:0] RSV_MASK = `FIC_RESERVED_SLOTS;

    logic [2:0]   pin_meta_r;
    logic [2:0]   pin_sync_r;
    logic [2:0]   pin_prev_r;
    logic [2:0]   ext_active;
    logic [2:0]   ext_fall;
    logic [2:0]   ext_trig;
    fic_flags_t   set_v;
    fic_flags_t   clr_v;
    fic_flags_t   follow_v;
    fic_flags_t   level_v;
    logic [NF-1:0] flag_flat;
    fic_flags_t   fl;
    logic [NS-1:0] src_raw;
    logic [NS-1:0] src_pend;
    logic         win_found;
    logic [4:0]   win_idx;
    fic_rank_t    win_rank;
    fic_rank_t    svc_top;
    logic         preempt_ok;
    logic         acked;
    fic_cpu_req_t cpu_req_r;
    logic [3:0]   in_service_r;
    logic [3:0]   in_service_nxt;

    ////////////////////////////////////////////////////////////////////////
    // External pins: two-stage synchroniser, then edge detect

    // Pins idle high, so reset to the released level
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_meta_r <= {3{`FIC_PIN_RST}};
            pin_sync_r <= {3{`FIC_PIN_RST}};
            pin_prev_r <= {3{`FIC_PIN_RST}};
        end else begin
            pin_meta_r <= {ext_irq_pin_two_n, ext_irq_pin_one_n,
                           ext_irq_pin_zero_n};
            pin_sync_r <= pin_meta_r;
            pin_prev_r <= pin_sync_r;
        end
    end

    // Low level asserts, falling edge triggers
    assign ext_active = ~pin_sync_r;
    assign ext_fall   = ~pin_sync_r & pin_prev_r;
    assign ext_trig   = {ext2_trigger_type, ext1_trigger_type,
                         ext0_trigger_type};

    ////////////////////////////////////////////////////////////////////////
    // Flag controls: set sources, follow mode, auto clear

    assign acked = vector_ack && cpu_req_r.req;

    // Hardware sets; external flags set on an edge in transition mode
    always_comb begin
        set_v = hw_flag_set;
        set_v.ext0_request_flag = ext_trig[0] & ext_fall[0];
        set_v.ext1_request_flag = ext_trig[1] & ext_fall[1];
        set_v.ext2_request_flag = ext_trig[2] & ext_fall[2];
    end

    // Level mode: flag mirrors the pin
    always_comb begin
        follow_v = '0;
        level_v  = '0;
        follow_v.ext0_request_flag = ~ext_trig[0];
        follow_v.ext1_request_flag = ~ext_trig[1];
        follow_v.ext2_request_flag = ~ext_trig[2];
        level_v.ext0_request_flag  = ext_active[0];
        level_v.ext1_request_flag  = ext_active[1];
        level_v.ext2_request_flag  = ext_active[2];
    end

    // Only edge-mode external and timer 0/1 flags clear on vectoring
    always_comb begin
        clr_v = '0;
        if (acked) begin
            unique case (cpu_req_r.src)
                `FIC_SRC_EXT0: clr_v.ext0_request_flag = ext_trig[0];
                `FIC_SRC_EXT1: clr_v.ext1_request_flag = ext_trig[1];
                `FIC_SRC_EXT2: clr_v.ext2_request_flag = ext_trig[2];
                `FIC_SRC_TMR0: clr_v.timer0_overflow_flag = 1'b1;
                `FIC_SRC_TMR1: clr_v.timer1_overflow_flag = 1'b1;
                default: clr_v = '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flag storage, one cell per flag

    for (genvar g = 0; g < NF; g++) begin : g_flag
        fic_flag u_flag (
            .clk     (clk),
            .resetn  (resetn),
            .hw_set  (set_v[g]),
            .hw_clr  (clr_v[g]),
            .sw_wr   (sw_flag_wr[g]),
            .sw_data (sw_flag_data[g]),
            .follow  (follow_v[g]),
            .level   (level_v[g]),
            .flag_r  (flag_flat[g])
        );
    end

    assign fl = fic_flags_t'(flag_flat);

    ////////////////////////////////////////////////////////////////////////
    // Per-slot requests from the stored flags

    always_comb begin
        src_raw = '0;
        src_raw[`FIC_SRC_EXT0] = fl.ext0_request_flag;
        src_raw[`FIC_SRC_TMR0] = fl.timer0_overflow_flag;
        src_raw[`FIC_SRC_EXT1] = fl.ext1_request_flag;
        src_raw[`FIC_SRC_TMR1] = fl.timer1_overflow_flag;
        src_raw[`FIC_SRC_UART0] = fl.uart0_receive_flag
                                | fl.uart0_transmit_flag;
        src_raw[`FIC_SRC_TMR2] = fl.timer2_overflow_flag
                               | fl.timer2_external_flag
                               | fl.timer2_low_half_overflow;
        src_raw[`FIC_SRC_EXT2] = fl.ext2_request_flag;
        src_raw[`FIC_SRC_SPI] = fl.serial_periph_done_flag;
        src_raw[`FIC_SRC_ADC] = fl.conversion_done_flag;
        src_raw[`FIC_SRC_PCA] = fl.counter_array_overflow_flag
                              | (|fl.compare_module_flags);
        src_raw[`FIC_SRC_SYS] = fl.clock_overflow_flag
                              | fl.brownout_zero_flag
                              | fl.brownout_one_flag
                              | fl.watchdog_overflow_flag
                              | fl.bus_start_detect_flag
                              | fl.bus_stop_detect_flag
                              | (fl.uart0_transmit_flag
                                 & uart_tx_sysflag_route);
        src_raw[`FIC_SRC_KBD] = fl.keypad_match_flag;
        src_raw[`FIC_SRC_TWI] = fl.twi_state_flag;
        src_raw[`FIC_SRC_UART1] = fl.uart1_receive_flag
                                | fl.uart1_transmit_flag;
        src_raw[`FIC_SRC_TMR3] = fl.timer3_overflow_flag
                               | fl.timer3_external_flag
                               | fl.timer3_low_half_overflow;
        src_raw[`FIC_SRC_DMA] = fl.dma_complete_flag
                              | fl.dma_timer_a_flag
                              | fl.dma_timer_b_flag;
    end

    // Gate by own enable and global enable; reserved slots never pend
    assign src_pend = src_raw & src_enable & ~`FIC_RESERVED_SLOTS
                    & {NS{global_irq_enable}};

    ////////////////////////////////////////////////////////////////////////
    // Arbitration: highest rank, lowest slot among equals

    // Walk from slot 18 down; ties overwrite, so the lowest slot wins
    always_comb begin
        fic_rank_t rk;
        rk        = '0;
        win_found = 1'b0;
        win_idx   = '0;
        win_rank  = '0;
        for (int i = NS - 1; i >= 0; i--) begin
            rk = {priority_high_bit[i], priority_low_bit[i]};
            if (src_pend[i] && (!win_found || rk >= win_rank)) begin
                win_found = 1'b1;
                win_idx   = 5'(i);
                win_rank  = rk;
            end
        end
    end

    // Highest level now in service
    always_comb begin
        svc_top = '0;
        for (int k = 0; k < 4; k++) begin
            if (in_service_r[k]) begin
                svc_top = 2'(k);
            end
        end
    end

    // Only a strictly higher level may preempt
    assign preempt_ok = (in_service_r == `FIC_SVC_RST)
                     || (win_rank > svc_top);

    ////////////////////////////////////////////////////////////////////////
    // Request to the core, registered

    // Acknowledge drops the strobe so a cleared flag is not presented twice
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cpu_req_r <= '0;
        end else if (acked) begin
            cpu_req_r.req <= 1'b0;
        end else begin
            cpu_req_r.req    <= win_found && preempt_ok;
            cpu_req_r.src    <= win_idx;
            cpu_req_r.vector <= `FIC_VEC_BASE
                              + {8'h00, win_idx, 3'b000};
            cpu_req_r.rank   <= win_rank;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // In-service levels: set on vectoring, highest cleared on return

    always_comb begin
        in_service_nxt = in_service_r;
        if (service_return) begin
            in_service_nxt[svc_top] = 1'b0;
        end
        if (acked) begin
            in_service_nxt[cpu_req_r.rank] = 1'b1;
        end
    end

    // Level bookkeeping
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            in_service_r <= `FIC_SVC_RST;
        end else begin
            in_service_r <= in_service_nxt;
        end
    end

    assign cpu_req    = cpu_req_r;
    assign flag_state = fl;
    assign in_service = in_service_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    logic [18:0] en_d_r;
    logic [18:0] hi_d_r;
    logic [18:0] lo_d_r;
    logic        glob_d_r;
    logic [3:0]  svc_d_r;
    fic_rank_t   top_d_r;

    // Controls as seen by the arbiter one cycle back
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            en_d_r  <= '0;
            hi_d_r  <= '0;
            lo_d_r  <= '0;
            glob_d_r <= 1'b0;
            svc_d_r <= '0;
            top_d_r <= '0;
        end else begin
            en_d_r  <= src_enable;
            hi_d_r  <= priority_high_bit;
            lo_d_r  <= priority_low_bit;
            glob_d_r <= global_irq_enable;
            svc_d_r <= in_service_r;
            top_d_r <= svc_top;
        end
    end

    // Strobe needs global and own enable
    a_req_gated: assert property (
        cpu_req_r.req |-> glob_d_r && en_d_r[cpu_req_r.src])
        else $error("request presented while disabled");

    // Reserved slots never win
    a_no_reserved: assert property (
        cpu_req_r.req |-> !RSV_MASK[cpu_req_r.src])
        else $error("reserved slot presented");

    // Vector is base plus eight per slot
    a_vector_map: assert property (
        cpu_req_r.req |-> cpu_req_r.vector
            == 16'h0003 + 16'(cpu_req_r.src) * 16'h0008)
        else $error("vector address wrong");

    // Rank comes from the slot's own pair
    a_rank_pair: assert property (
        cpu_req_r.req |-> cpu_req_r.rank
            == {hi_d_r[cpu_req_r.src], lo_d_r[cpu_req_r.src]})
        else $error("priority rank wrong");

    // Nothing at or below the active level
    a_no_preempt: assert property (
        cpu_req_r.req && (svc_d_r != 4'h0) |-> cpu_req_r.rank > top_d_r)
        else $error("preemption by lower level");

    // Strobe falls after acknowledge
    a_ack_drops: assert property (
        vector_ack && cpu_req_r.req |=> !cpu_req_r.req)
        else $error("strobe held after ack");

    // Timer 0 overflow cleared by vectoring
    a_tmr0_clear: assert property (
        acked && cpu_req_r.src == `FIC_SRC_TMR0
        && !hw_flag_set.timer0_overflow_flag
        && !sw_flag_wr.timer0_overflow_flag
        |=> !fl.timer0_overflow_flag)
        else $error("timer 0 flag not auto-cleared");

    // Level mode external flag mirrors the pin
    a_ext_follow: assert property (
        $past(!ext0_trigger_type) |->
        fl.ext0_request_flag == $past(ext_active[0]))
        else $error("level flag does not follow pin");

    // Serial port 0 receive flag survives vectoring
    a_uart0_kept: assert property (
        acked && fl.uart0_receive_flag
        && !sw_flag_wr.uart0_receive_flag
        |=> fl.uart0_receive_flag)
        else $error("uart0 flag cleared by vectoring");

    // Conversion flag held for two cycles without software
    a_adc_kept: assert property (
        fl.conversion_done_flag && !sw_flag_wr.conversion_done_flag
        ##1 !sw_flag_wr.conversion_done_flag
        |=> fl.conversion_done_flag)
        else $error("conversion flag lost");

    // Software write of one sets the flag
    a_sw_set: assert property (
        sw_flag_wr.serial_periph_done_flag
        && sw_flag_data.serial_periph_done_flag
        |=> fl.serial_periph_done_flag)
        else $error("software set ignored");

endmodule : fic_top

// *** verification/fic_core_model.sv ***
// Core model: takes presented vectors, leaves service after a while.
// Assumes one clock; drives only after falling edges.
`timescale 1ns/1ps
module fic_core_model (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       req,
    input  wire logic [3:0] delay,
    input  wire logic [7:0] svc_len,
    output logic            vector_ack = 1'b0,
    output logic            service_return = 1'b0
);
    int wait_c;
    int svc_c;
    int depth;
    //////////////////////////
    // Ack after delay, one return per taken vector
    always @(negedge clk or negedge resetn) begin
        if (!resetn) begin
            vector_ack     <= 1'b0;
            service_return <= 1'b0;
            wait_c         <= 0;
            depth          <= 0;
            svc_c          <= 0;
        end else begin
            vector_ack     <= 1'b0;
            service_return <= 1'b0;
            if (req && !vector_ack && wait_c >= delay) begin
                vector_ack <= 1'b1;
                wait_c     <= 0;
                depth      <= depth + 1;
                svc_c      <= svc_len;
            end else begin
                wait_c <= (req && !vector_ack) ? wait_c + 1 : 0;
                if (depth > 0 && svc_c == 0) begin
                    service_return <= 1'b1;
                    depth          <= depth - 1;
                    svc_c          <= svc_len;
                end else if (depth > 0) begin
                    svc_c <= svc_c - 1;
                end
            end
        end
    end
endmodule : fic_core_model

// *** verification/testbench.sv ***
// Self-checking bench of the interrupt controller with a core model.
// Assumes fic_pkg and the core model are compiled first.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
    err_count++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module testbench;
    import fic_pkg::*;
    logic         clk = 1'b0;
    logic         resetn = 1'b0;
    logic         gie = 1'b0;
    logic         route = 1'b0;
    logic [2:0]   trig = 3'h0;
    logic [2:0]   pin_n = 3'h7;
    logic [18:0]  en = '0;
    logic [18:0]  phi = '0;
    logic [18:0]  plo = '0;
    fic_flags_t   hws = '0;
    fic_flags_t   swr = '0;
    fic_flags_t   swd = '0;
    fic_flags_t   fs;
    fic_cpu_req_t cr;
    logic         ack;
    logic         ret;
    logic [3:0]   insvc;
    logic [3:0]   dly = 4'h0;
    logic [7:0]   slen = 8'h28;
    logic [20:0]  q[$];
    logic [20:0]  exp_v;
    int           err_count = 0;
    int           compares = 0;
    int           seed = 32'h7e42_6792;
    int slot_tab[32] = '{18, 18, 18, 12, 11, 10, 10, 10, 10, 10, 10, 9, 9,
        9, 9, 9, 9, 9, 8, 7, 16, 16, 16, 5, 5, 5, 14, 14, 4, 4, 3, 1};
    //////////////////////////
    // Clock and instances
    always #5 clk = ~clk;
    fic_top DUT (
        .clk(clk), .resetn(resetn), .global_irq_enable(gie),
        .src_enable(en), .priority_high_bit(phi), .priority_low_bit(plo),
        .ext0_trigger_type(trig[0]), .ext1_trigger_type(trig[1]),
        .ext2_trigger_type(trig[2]), .uart_tx_sysflag_route(route),
        .ext_irq_pin_zero_n(pin_n[0]), .ext_irq_pin_one_n(pin_n[1]),
        .ext_irq_pin_two_n(pin_n[2]), .hw_flag_set(hws),
        .sw_flag_wr(swr), .sw_flag_data(swd), .vector_ack(ack),
        .service_return(ret), .cpu_req(cr), .flag_state(fs),
        .in_service(insvc)
    );
    fic_core_model core (.clk(clk), .resetn(resetn), .req(cr.req),
        .delay(dly), .svc_len(slen), .vector_ack(ack),
        .service_return(ret));
    //////////////////////////
    // Scoreboard: each taken vector against the oldest note
    always @(posedge clk) begin
        if (resetn && cr.req && ack) begin
            exp_v = (q.size() != 0) ? q.pop_front() : 21'h1f_ffff;
            `CHK("vector", exp_v, {cr.src, cr.vector})
        end
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    task automatic note(input int sl);
        q.push_back({sl[4:0], 16'h0003 + 16'(8 * sl)});
    endtask : note
    // Pulse one flag bit by hardware or by software write
    task automatic pulse(input int b, input bit by_sw);
        if (by_sw) swr[b] = 1'b1;
        else hws[b] = 1'b1;
        swd[b] = 1'b1;
        tick(1);
        hws = '0;
        swr = '0;
        swd = '0;
    endtask : pulse
    task automatic drain(input bit full);
        int i;
        for (i = 0; i < 400 && (q.size() != 0
            || (full && insvc !== 4'h0)); i++) tick(1);
        `CHK("drained", 1'b1,
             q.size() == 0 && (!full || insvc === 4'h0))
    endtask : drain
    task automatic report_and_stop;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    //////////////////////////
    // Watchdog
    initial begin
        #300000;
        err_count++;
        report_and_stop;
    end
    // Main sequence
    initial begin
        int i;
        int k;
        int s;
        int r1;
        int r3;
        tick(20);
        resetn = 1'b1;
        tick(2);
        gie = 1'b1;
        for (i = 0; i < 32; i++) begin
            en = 19'h1 << slot_tab[i];
            note(slot_tab[i]);
            pulse(i, i[0]);
            drain(0);
            `CHK("hold", (i < 30), fs[i])
            swr[i] = 1'b1;
            tick(1);
            swr = '0;
            `CHK("sw clear", 1'b0, fs[i])
            drain(1);
        end
        route = 1'b1;
        en = 19'h1 << 10;
        note(10);
        pulse(28, 1'b0);
        drain(0);
        route = 1'b0;
        drain(1);
        tick(3);
        `CHK("route off", 1'b0, cr.req)
        pulse(28, 1'b1);
        tick(2);
        `CHK("route off", 1'b0, cr.req)
        swr[28] = 1'b1;
        tick(1);
        swr = '0;
        gie = 1'b0;
        en = 19'h1 << 1;
        pulse(31, 1'b0);
        tick(6);
        `CHK("global off", 1'b0, cr.req)
        gie = 1'b1;
        en = '0;
        tick(6);
        `CHK("src off", 1'b0, cr.req)
        note(1);
        en = '1;
        drain(1);
        slen = 8'h06;
        for (k = 0; k < 8; k++) begin
            r1 = $random(seed) & 3;
            r3 = $random(seed) & 3;
            dly = 4'($random(seed) & 7);
            {phi[1], plo[1]} = r1[1:0];
            {phi[3], plo[3]} = r3[1:0];
            note(r3 > r1 ? 3 : 1);
            note(r3 > r1 ? 1 : 3);
            hws[31:30] = 2'b11;
            tick(1);
            hws = '0;
            drain(1);
        end
        slen = 8'h3c;
        {phi[1], plo[1], phi[3], plo[3]} = 4'h3;
        note(1);
        pulse(31, 1'b0);
        drain(0);
        note(3);
        pulse(30, 1'b0);
        drain(0);
        `CHK("nested", 4'h9, insvc)
        drain(1);
        for (k = 0; k < 3; k++) begin
            s = (k == 2) ? 6 : 2 * k;
            en = 19'h1 << s;
            trig[k] = 1'b1;
            note(s);
            pin_n[k] = 1'b0;
            drain(0);
            `CHK("edge clear", 1'b0, fs[34 - k])
            pin_n[k] = 1'b1;
            drain(1);
            en = '0;
            trig[k] = 1'b0;
            pin_n[k] = 1'b0;
            tick(5);
            `CHK("level set", 1'b1, fs[34 - k])
            pin_n[k] = 1'b1;
            tick(5);
            `CHK("level drop", 1'b0, fs[34 - k])
        end
        report_and_stop;
    end
endmodule : testbench
